//--- hcssp_pkg.sv
// Package for the host command synchronous serial port.
// Assumes a single 100 MHz system clock; all pins are sampled into that domain.
package hcssp_pkg;
   localparam int unsigned UNIT_BITS = 8;
   localparam logic [2:0] CNT_RESET = 3'h0;
   localparam logic [2:0] CNT_LAST = 3'h7;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [2:0] SYNC_RESET = 3'h0;
   localparam logic [2:0] SYNC_CS_RESET = 3'h7;

   typedef enum logic [2:0] {
      HCSSP_IDLE = 3'b001,
      HCSSP_SHIFT = 3'b010,
      HCSSP_BUSY = 3'b100
   } hcssp_state_e;

   // Pins as seen by the port after synchronisation.
   typedef struct packed {
      logic sclk;
      logic sdi;
      logic chip_select_n;
      logic clock_phase_select;
   } hcssp_pins_s;

   // Command unit handed to the core and its completion.
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } hcssp_cmd_s;
endpackage : hcssp_pkg

//--- hcssp_sync.sv
// Three-stage pin synchroniser; a change is accepted once stages two and three agree.
// Assumes asynchronous pins and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module hcssp_sync #(
   parameter logic RESET_VALUE = 1'b0
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   typedef struct packed {
      logic [2:0] stage;
      logic level;
   } hcssp_sync_s;

   hcssp_sync_s state;
   hcssp_sync_s next_state;

   always_comb begin
      next_state = state;
      next_state.stage = {state.stage[1:0], pin};
      if (state.stage[1] == state.stage[2]) begin
         next_state.level = state.stage[2];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= {{3{RESET_VALUE}}, RESET_VALUE};
      end else begin
         state <= next_state;
      end
   end

   assign level = state.level;
endmodule : hcssp_sync
`default_nettype wire

//--- hcssp_port.sv
// Host command synchronous serial port: serial shift-in of command units, serial
// shift-out of a reply byte, and the command busy handshake.
// Assumes the serial clock is far slower than mclk (100 ns period against 10 ns).
//
// Function
// - With phase select low, input is sampled on each rising serial clock edge.
// - With phase select low, output changes on each falling serial clock edge.
// - With phase select high, input is sampled on each falling serial clock edge.
// - With phase select high, output changes on each rising serial clock edge.
// - Transfers happen only while chip select is low; otherwise pins are ignored.
// - The serial output is released whenever chip select is high.
// - In reset the output is released and the port returns to its initial state.
// - Busy is driven low while a command is processed; host waits for it high.
// - Holding reset low returns all logic to its initial state and halts it.
`timescale 1ns/1ps
`default_nettype none
module hcssp_port #(
   parameter int unsigned BUSY_CYCLES = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic chip_select_n,
   input wire logic clock_phase_select,
   output logic sdo,
   output logic sdo_oe,
   output logic command_busy_n,
   output logic cmd_valid,
   output logic [7:0] cmd_data,
   input wire logic [7:0] reply_data
);
   if (BUSY_CYCLES < 1 || BUSY_CYCLES > 255) begin : g_bad_busy
      $error("BUSY_CYCLES must lie in 1..255");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset levels match the idle pins, so no false edge or select follows reset.
   localparam hcssp_pkg::hcssp_pins_s SYNC_INIT = '{
      sclk: 1'b0,
      sdi: 1'b0,
      chip_select_n: 1'b1,
      clock_phase_select: 1'b0
   };

   hcssp_pkg::hcssp_pins_s pins;
   hcssp_pkg::hcssp_pins_s raw_pins;
   logic [3:0] sync_pins;

   assign raw_pins = '{
      sclk: sclk,
      sdi: sdi,
      chip_select_n: chip_select_n,
      clock_phase_select: clock_phase_select
   };

   for (genvar g = 0; g < 4; g++) begin : g_sync
      hcssp_sync #(
         .RESET_VALUE(SYNC_INIT[g])
      ) u_sync (
         .mclk(mclk),
         .rst_n(rst_n),
         .pin(raw_pins[g]),
         .level(sync_pins[g])
      );
   end

   assign pins = sync_pins;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      hcssp_pkg::hcssp_state_e fsm;
      logic sclk_prev;
      logic [2:0] bit_cnt;
      logic [7:0] shift_in;
      logic [7:0] shift_out;
      logic sdo;
      logic oe;
      logic [7:0] busy_cnt;
      hcssp_pkg::hcssp_cmd_s cmd;
   } hcssp_port_s;

   hcssp_port_s state;
   hcssp_port_s next_state;

   logic rise;
   logic fall;
   logic sample_edge;
   logic launch_edge;
   logic selected;

   assign rise = pins.sclk && !state.sclk_prev;
   assign fall = !pins.sclk && state.sclk_prev;
   assign selected = !pins.chip_select_n;
   // Phase select low: sample on rise, launch on fall; high swaps them.
   assign sample_edge = selected && (pins.clock_phase_select ? fall : rise);
   assign launch_edge = selected && (pins.clock_phase_select ? rise : fall);

   always_comb begin
      next_state = state;
      next_state.sclk_prev = pins.sclk;
      next_state.cmd.valid = 1'b0;
      next_state.oe = selected;
      case (state.fsm)
         hcssp_pkg::HCSSP_IDLE: begin
            next_state.bit_cnt = hcssp_pkg::CNT_RESET;
            if (selected) begin
               next_state.fsm = hcssp_pkg::HCSSP_SHIFT;
               next_state.shift_out = reply_data;
               next_state.sdo = reply_data[7];
            end
         end
         hcssp_pkg::HCSSP_SHIFT: begin
            if (!selected) begin
               // Partial unit dropped so the next select starts on a clean boundary.
               next_state.fsm = hcssp_pkg::HCSSP_IDLE;
               next_state.bit_cnt = hcssp_pkg::CNT_RESET;
            end else begin
               if (launch_edge && state.bit_cnt != hcssp_pkg::CNT_RESET) begin
                  next_state.sdo = state.shift_out[7];
               end
               if (sample_edge) begin
                  next_state.shift_in = {state.shift_in[6:0], pins.sdi};
                  next_state.shift_out = {state.shift_out[6:0], 1'b0};
                  next_state.bit_cnt = state.bit_cnt + 3'h1;
                  if (state.bit_cnt == hcssp_pkg::CNT_LAST) begin
                     next_state.cmd.valid = 1'b1;
                     next_state.cmd.data = {state.shift_in[6:0], pins.sdi};
                     next_state.busy_cnt = 8'(BUSY_CYCLES);
                     next_state.fsm = hcssp_pkg::HCSSP_BUSY;
                  end
               end
            end
         end
         hcssp_pkg::HCSSP_BUSY: begin
            next_state.bit_cnt = hcssp_pkg::CNT_RESET;
            next_state.busy_cnt = state.busy_cnt - 8'h01;
            if (state.busy_cnt == 8'h01) begin
               next_state.fsm = hcssp_pkg::HCSSP_IDLE;
            end
         end
         default: begin
            next_state.fsm = hcssp_pkg::HCSSP_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state.fsm <= hcssp_pkg::HCSSP_IDLE;
         state.sclk_prev <= 1'b0;
         state.bit_cnt <= hcssp_pkg::CNT_RESET;
         state.shift_in <= hcssp_pkg::BYTE_RESET;
         state.shift_out <= hcssp_pkg::BYTE_RESET;
         state.sdo <= 1'b0;
         state.oe <= 1'b0;
         state.busy_cnt <= hcssp_pkg::BYTE_RESET;
         state.cmd <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sdo = state.sdo;
   assign sdo_oe = state.oe;
   assign command_busy_n = (state.fsm != hcssp_pkg::HCSSP_BUSY);
   assign cmd_valid = state.cmd.valid;
   assign cmd_data = state.cmd.data;

   ////////////////////////////////////////////////////////////////////////////
   property p_oe_off_deselected;
      @(posedge mclk) disable iff (!rst_n)
         pins.chip_select_n |=> !sdo_oe;
   endproperty
   a_oe_off_deselected: assert property (p_oe_off_deselected)
      else $error("Output enabled while deselected.");

   property p_busy_after_unit;
      @(posedge mclk) disable iff (!rst_n)
         cmd_valid |-> !command_busy_n ##1 (BUSY_CYCLES == 1 || !command_busy_n);
   endproperty
   a_busy_after_unit: assert property (p_busy_after_unit)
      else $error("Busy not asserted after a command unit.");

   property p_valid_single;
      @(posedge mclk) disable iff (!rst_n)
         cmd_valid |=> !cmd_valid;
   endproperty
   a_valid_single: assert property (p_valid_single)
      else $error("Command unit pulse longer than one cycle.");

   property p_busy_ends;
      @(posedge mclk) disable iff (!rst_n)
         $fell(command_busy_n) |-> ##[1:300] command_busy_n;
   endproperty
   a_busy_ends: assert property (p_busy_ends)
      else $error("Busy never released.");

   property p_rise_sample;
      @(posedge mclk) disable iff (!rst_n)
         (state.fsm == hcssp_pkg::HCSSP_SHIFT && selected && !pins.clock_phase_select && rise)
         |=> state.shift_in[0] == $past(pins.sdi);
   endproperty
   a_rise_sample: assert property (p_rise_sample)
      else $error("Input not sampled on rising edge.");

   property p_fall_sample;
      @(posedge mclk) disable iff (!rst_n)
         (state.fsm == hcssp_pkg::HCSSP_SHIFT && selected && pins.clock_phase_select && fall)
         |=> state.shift_in[0] == $past(pins.sdi);
   endproperty
   a_fall_sample: assert property (p_fall_sample)
      else $error("Input not sampled on falling edge.");

   property p_out_stable_rise;
      @(posedge mclk) disable iff (!rst_n)
         (selected && !pins.clock_phase_select && !fall && state.fsm == hcssp_pkg::HCSSP_SHIFT)
         |=> $stable(sdo) || $past(state.fsm) != hcssp_pkg::HCSSP_SHIFT;
   endproperty
   a_out_stable_rise: assert property (p_out_stable_rise)
      else $error("Output changed away from falling edge.");

   property p_out_stable_fall;
      @(posedge mclk) disable iff (!rst_n)
         (selected && pins.clock_phase_select && !rise && state.fsm == hcssp_pkg::HCSSP_SHIFT)
         |=> $stable(sdo);
   endproperty
   a_out_stable_fall: assert property (p_out_stable_fall)
      else $error("Output changed away from rising edge.");

   property p_drop_partial;
      @(posedge mclk) disable iff (!rst_n)
         (state.fsm == hcssp_pkg::HCSSP_SHIFT && pins.chip_select_n)
         |=> state.bit_cnt == hcssp_pkg::CNT_RESET && !cmd_valid;
   endproperty
   a_drop_partial: assert property (p_drop_partial)
      else $error("Partial unit not discarded.");
endmodule : hcssp_port
`default_nettype wire

//--- hcssp_host.sv
// Behavioural host that masters the serial command link of the port.
// Assumes a 100 ns serial clock that stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module hcssp_host (
   output var logic sclk,
   output var logic sdi,
   output var logic chip_select_n,
   input wire logic sdo_line
);
   localparam time HALF = 40;
   initial begin
      sclk = 1'b0;
      sdi = 1'b0;
      chip_select_n = 1'b1;
   end
   // Sends the top n bits of tx and reads sdo just before each launch edge.
   // The port answers several mclk after an edge, so reading on the sampling edge would be stale.
   task automatic frame(input logic ph, input int n, input logic [7:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      sclk = ph;
      #(2 * HALF);
      chip_select_n = 1'b0;
      #(2 * HALF);
      for (int i = 7; i >= 8 - n; i--) begin
         sdi = tx[i];
         #(HALF);
         sclk = ~ph;
         #(HALF - 5);
         rx[i] = sdo_line;
         #5;
         sclk = ph;
         #20;
      end
      #(HALF);
      chip_select_n = 1'b1;
      sdi = ~sdi;
   endtask : frame
   // Toggles clock and data while deselected.
   task automatic wiggle(input int n);
      for (int i = 0; i < n; i++) begin
         #(HALF);
         sclk = ~sclk;
         sdi = ~sdi;
      end
   endtask : wiggle
endmodule : hcssp_host
`default_nettype wire

//--- hcssp_port_tb.sv
// Self-checking bench for the serial command port.
// Assumes the host model drives the link; bench owns reset, phase select and reply data.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin err_total++; $display("[FAIL] %0t %s", $time, m); end end
module hcssp_port_tb;
   localparam int unsigned BUSY = 5;
   logic mclk, rst_n, clock_phase_select, sclk, sdi, chip_select_n;
   logic sdo, sdo_oe, command_busy_n, cmd_valid;
   logic [7:0] cmd_data, reply_data, got, rx;
   wire logic sdo_line;
   int err_total = 0, checks_done = 0, n_valid = 0, busy_len = 0, cycles = 0;
   assign sdo_line = sdo_oe ? sdo : 1'bz;
   hcssp_port #(.BUSY_CYCLES(BUSY)) u_dut (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .sdi(sdi),
      .chip_select_n(chip_select_n), .clock_phase_select(clock_phase_select), .sdo(sdo),
      .sdo_oe(sdo_oe), .command_busy_n(command_busy_n), .cmd_valid(cmd_valid),
      .cmd_data(cmd_data), .reply_data(reply_data));
   hcssp_host u_host (.sclk(sclk), .sdi(sdi), .chip_select_n(chip_select_n), .sdo_line(sdo_line));
   always #5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      cycles++;
      if (cmd_valid === 1'b1) begin
         n_valid++;
         got = cmd_data;
      end
      if (command_busy_n === 1'b0) busy_len++;
      if (cycles > 5000) begin
         err_total++;
         conclude();
      end
   end
   task automatic conclude();
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   task automatic check_idle();
      `CHK(sdo_oe, 1'b0, "sdo driven")
      `CHK(command_busy_n, 1'b1, "busy in reset")
      `CHK(cmd_valid, 1'b0, "valid in reset")
      `CHK(cmd_data, 8'h00, "data in reset")
   endtask : check_idle
   task automatic xfer(input logic ph, input logic [7:0] tx, input logic [7:0] rep);
      int v0;
      @(posedge mclk);
      #1;
      clock_phase_select = ph;
      reply_data = rep;
      repeat (8) @(posedge mclk);
      #1;
      v0 = n_valid;
      busy_len = 0;
      u_host.frame(ph, 8, tx, rx);
      // The deselect needs the synchroniser and one register before the output lets go.
      repeat (6) @(posedge mclk);
      #1;
      `CHK(sdo_oe, 1'b0, "sdo not released")
      `CHK(rx, rep, "reply byte")
      `CHK(n_valid - v0, 1, "unit count")
      `CHK(got, tx, "unit data")
      for (int k = 0; k < 300 && command_busy_n !== 1'b1; k++) @(posedge mclk);
      `CHK(busy_len, BUSY, "busy length")
   endtask : xfer
   // A partial unit must vanish, so the next full unit must arrive intact.
   task automatic partial_then_full();
      int v0;
      @(posedge mclk);
      #1;
      v0 = n_valid;
      u_host.frame(1'b0, 5, 8'hf0, rx);
      repeat (10) @(posedge mclk);
      `CHK(n_valid - v0, 0, "partial unit kept")
      xfer(1'b0, 8'h81, 8'h7e);
   endtask : partial_then_full
   task automatic deselected_noise();
      int v0;
      @(posedge mclk);
      #1;
      v0 = n_valid;
      u_host.wiggle(20);
      repeat (10) @(posedge mclk);
      `CHK(n_valid - v0, 0, "unit while deselected")
      `CHK(sdo_oe, 1'b0, "sdo driven while deselected")
   endtask : deselected_noise
   task automatic reset_mid_frame();
      @(posedge mclk);
      #1;
      fork
         u_host.frame(1'b0, 8, 8'h33, rx);
         begin
            #400;
            @(posedge mclk);
            #1;
            rst_n = 1'b0;
            repeat (2) @(posedge mclk);
            #1;
            check_idle();
         end
      join
      @(posedge mclk);
      #1;
      rst_n = 1'b1;
      xfer(1'b1, 8'h96, 8'h69);
   endtask : reset_mid_frame
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      clock_phase_select = 1'b0;
      reply_data = 8'h00;
      repeat (3) @(posedge mclk);
      #1;
      check_idle();
      rst_n = 1'b1;
      xfer(1'b0, 8'ha5, 8'h3c);
      xfer(1'b1, 8'h5a, 8'hc3);
      xfer(1'b1, 8'h01, 8'h80);
      partial_then_full();
      deselected_noise();
      reset_mid_frame();
      conclude();
   end
endmodule : hcssp_port_tb
`default_nettype wire
